// file: mms_top.sv
//  Purpose: management, flags and serial memory of a four-lane module
//  Assumes: serial_clk_in runs free and oversamples the bus pins
//  Notes:   flags live in the core domain, the bus engine in the link
`timescale 1ns/10ps
module mms_top
    import mms_pkg::*;
#(
    parameter int unsigned INIT_CYCLES = INIT_CYC
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             serial_clk_in,
    input  wire logic             module_reset_n_in,
    input  wire logic             low_power_select_in,
    input  wire logic [LANES-1:0] rx_los_in,
    input  wire logic [LANES-1:0] tx_fault_in,
    input  wire logic [15:0]      monitor_in,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe_n_out,
    output logic                  interrupt_out_n_out,
    output logic                  low_power_active_out,
    output logic                  data_not_ready_out
);

    // ****************************************
    // core domain
    // ****************************************
    logic [1:0]        mrst_sync_reg;
    logic [1:0]        lp_sync_reg;
    logic [LANES-1:0]  los_s1_reg, los_s2_reg, los_d_reg;
    logic [LANES-1:0]  flt_s1_reg, flt_s2_reg, flt_d_reg;
    logic [8:0]        rst_cnt_reg;
    logic              mod_rst_reg;
    logic [31:0]       init_cnt_reg;
    logic              init_last;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] set_vec;
    logic [2:0]        ct_sync_reg;
    logic              clr_go;
    logic [15:0]       mon_hold_reg;
    logic [1:0]        busy_sync_reg;
    logic              busy_reg;
    logic              clr_tgl_reg;
    logic [FLAG_W-1:0] clr_mask_reg;

    // pin synchronisers; the second stage is read, and for the lane inputs also a third stage for edges
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mrst_sync_reg <= 2'h3;
            lp_sync_reg <= 2'h0;
            los_s1_reg <= 4'h0;
            los_s2_reg <= 4'h0;
            los_d_reg <= 4'h0;
            flt_s1_reg <= 4'h0;
            flt_s2_reg <= 4'h0;
            flt_d_reg <= 4'h0;
        end else begin
            mrst_sync_reg <= {mrst_sync_reg[0], module_reset_n_in};
            lp_sync_reg <= {lp_sync_reg[0], low_power_select_in};
            los_s1_reg <= rx_los_in;
            los_s2_reg <= los_s1_reg;
            los_d_reg <= los_s2_reg;
            flt_s1_reg <= tx_fault_in;
            flt_s2_reg <= flt_s1_reg;
            flt_d_reg <= flt_s2_reg;
        end
    end

    // reset pin filter: short glitches below the least pulse are ignored
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rst_cnt_reg <= 9'h000;
            mod_rst_reg <= 1'b0;
        end else if (mrst_sync_reg[1]) begin
            rst_cnt_reg <= 9'h000;
            mod_rst_reg <= 1'b0;
        end else if (rst_cnt_reg == RST_CYC) begin
            mod_rst_reg <= 1'b1;
        end else begin
            rst_cnt_reg <= rst_cnt_reg + 9'h001;
        end
    end

    // initialisation timer restarts on power-on and on reset release
    assign init_last = (init_cnt_reg == 32'(INIT_CYCLES - 1));
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            init_cnt_reg <= 32'h0000_0000;
            data_not_ready_out <= 1'b1;
        end else if (mod_rst_reg) begin
            init_cnt_reg <= 32'h0000_0000;
            data_not_ready_out <= 1'b1;
        end else if (data_not_ready_out) begin
            if (init_last) begin
                data_not_ready_out <= 1'b0;
            end else begin
                init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // events: rising conditions and the ready moment
    assign set_vec = {flt_s2_reg & ~flt_d_reg, los_s2_reg & ~los_d_reg,
                      data_not_ready_out & init_last & ~mod_rst_reg};

    // clear request toggle from the link; its mask is held stable meanwhile
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ct_sync_reg <= 3'h0;
        end else begin
            ct_sync_reg <= {ct_sync_reg[1:0], clr_tgl_reg};
        end
    end
    assign clr_go = ct_sync_reg[2] ^ ct_sync_reg[1];

    // latched flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flags_reg <= '0;
        end else if (mod_rst_reg) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~(clr_go ? clr_mask_reg : '0))
                         | set_vec;
        end
    end

    // interrupt follows the flag set; no masking exists in this block
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            interrupt_out_n_out <= 1'b1;
        end else begin
            interrupt_out_n_out <= ~(|flags_reg);
        end
    end

    // low-power request reaches the power control in three cycles
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            low_power_active_out <= 1'b0;
        end else begin
            low_power_active_out <= lp_sync_reg[1];
        end
    end

    // monitor snapshot frozen while a bus transaction runs
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            busy_sync_reg <= 2'h0;
            mon_hold_reg <= 16'h0000;
        end else begin
            busy_sync_reg <= {busy_sync_reg[0], busy_reg};
            if (!busy_sync_reg[1]) begin
                mon_hold_reg <= monitor_in;
            end
        end
    end

    // ****************************************
    // link domain
    // ****************************************
    logic [1:0]        scl_sync_reg, sda_sync_reg;
    logic              scl_d_reg, sda_d_reg;
    logic [FLAG_W-1:0] flg_s1_reg, flg_s2_reg;
    logic [1:0]        dnr_sync_reg, en_sync_reg;
    logic              start_det, stop_det, scl_rise, scl_fall;
    logic              ctl_ok, byte_done, load_go, wr_go;
    mms_state_e        state_reg;
    logic [3:0]        bit_cnt_reg;
    logic [7:0]        shift_reg, ptr_reg, page_reg, rd_byte;
    logic              rw_reg, first_reg;
    logic [FLAG_W-1:0] rd_clr, clr_pend_reg;
    logic [7:0]        upper_mem [0:PAGES*128-1];

    // bus pins and core levels, two flops before any use
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            flg_s1_reg <= '0;
            flg_s2_reg <= '0;
            dnr_sync_reg <= 2'h3;
            en_sync_reg <= 2'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
            flg_s1_reg <= flags_reg;
            flg_s2_reg <= flg_s1_reg;
            dnr_sync_reg <= {dnr_sync_reg[0], data_not_ready_out};
            en_sync_reg <= {en_sync_reg[0], ~mod_rst_reg};
        end
    end

    // bus conditions seen on the synchronised pins
    assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
    assign stop_det = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
    assign scl_rise = scl_sync_reg[1] & ~scl_d_reg;
    assign scl_fall = ~scl_sync_reg[1] & scl_d_reg;
    assign ctl_ok = en_sync_reg[1] & ~stop_det & ~start_det;
    assign byte_done = scl_fall & (bit_cnt_reg == 4'h8);
    assign load_go = ctl_ok & scl_fall
                     & (((state_reg == ST_ACK) & rw_reg) | (state_reg == ST_MACK));
    assign wr_go = ctl_ok & byte_done & (state_reg == ST_WRITE) & ~first_reg;

    // read data: lower page fixed, upper half windows the selected page
    always_comb begin
        rd_byte = 8'h00;
        rd_clr = '0;
        if (ptr_reg[7]) begin
            rd_byte = upper_mem[{page_reg[1:0], ptr_reg[6:0]}];
        end else begin
            case (ptr_reg[6:0])
                ID_OFS: begin
                    rd_byte = ID_VALUE;
                end
                STATUS_OFS: begin
                    rd_byte = {6'h00, flg_s2_reg[FLG_READY], dnr_sync_reg[1]};
                    rd_clr[FLG_READY] = flg_s2_reg[FLG_READY];
                end
                LOS_OFS: begin
                    rd_byte = {4'h0, flg_s2_reg[FLG_LOS_LSB +: LANES]};
                    rd_clr[FLG_LOS_LSB +: LANES] = flg_s2_reg[FLG_LOS_LSB +: LANES];
                end
                FAULT_OFS: begin
                    rd_byte = {4'h0, flg_s2_reg[FLG_FAULT_LSB +: LANES]};
                    rd_clr[FLG_FAULT_LSB +: LANES] = flg_s2_reg[FLG_FAULT_LSB +: LANES];
                end
                MON_HI_OFS: begin
                    rd_byte = mon_hold_reg[15:8];
                end
                MON_LO_OFS: begin
                    rd_byte = mon_hold_reg[7:0];
                end
                PAGE_SEL_OFS: begin
                    rd_byte = page_reg;
                end
                default: begin
                    rd_byte = 8'h00;
                end
            endcase
        end
    end

    // bus engine; sda changes only after scl falls
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            busy_reg <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else if (!en_sync_reg[1] || stop_det) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else if (start_det) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            busy_reg <= 1'b1;
            sda_oe_n_out <= 1'b1;
        end else begin
            case (state_reg)
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_WRITE) begin
                            sda_oe_n_out <= 1'b0;
                            state_reg <= ST_ACK;
                            first_reg <= 1'b0;
                            ptr_reg <= first_reg ? shift_reg : ptr_reg + 8'h01;
                        end else if (shift_reg[7:1] == DEV_ADDR) begin
                            sda_oe_n_out <= 1'b0;
                            rw_reg <= shift_reg[0];
                            first_reg <= ~shift_reg[0];
                            state_reg <= ST_ACK;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (load_go) begin
                        shift_reg <= rd_byte;
                        sda_oe_n_out <= rd_byte[7];
                        ptr_reg <= ptr_reg + 8'h01;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_READ;
                    end else if (scl_fall) begin
                        sda_oe_n_out <= 1'b1;
                        state_reg <= ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        sda_oe_n_out <= 1'b1;
                        state_reg <= ST_MACK;
                    end else if (scl_fall) begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_n_out <= shift_reg[6];
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda_sync_reg[1]) begin
                        state_reg <= ST_IDLE;        // host ends the read
                    end else if (load_go) begin
                        shift_reg <= rd_byte;
                        sda_oe_n_out <= rd_byte[7];
                        ptr_reg <= ptr_reg + 8'h01;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_READ;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // page select and paged storage
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            page_reg <= PAGE_RST;
        end else if (wr_go && ptr_reg[6:0] == PAGE_SEL_OFS && !ptr_reg[7]) begin
            page_reg <= shift_reg;
        end
    end
    always_ff @(posedge serial_clk_in) begin
        if (wr_go && ptr_reg[7]) begin
            upper_mem[{page_reg[1:0], ptr_reg[6:0]}] <= shift_reg;
        end
    end

    // clear-on-read: bits seen set are cleared only once the stop arrives
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clr_pend_reg <= '0;
            clr_mask_reg <= '0;
            clr_tgl_reg <= 1'b0;
        end else if (stop_det) begin
            clr_pend_reg <= '0;
            if (|clr_pend_reg) begin
                clr_mask_reg <= clr_pend_reg;
                clr_tgl_reg <= ~clr_tgl_reg;
            end
        end else if (!en_sync_reg[1]) begin
            clr_pend_reg <= '0;
        end else if (load_go) begin
            clr_pend_reg <= clr_pend_reg | rd_clr;
        end
    end

    // open-drain data pin only ever pulls low
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence los_edge_s;
        !los_d_reg[0] && los_s2_reg[0] && !mod_rst_reg;
    endsequence
    sequence los_seen_s;
        ##1 flags_reg[FLG_LOS_LSB] ##1 !interrupt_out_n_out;
    endsequence

    rst_filter_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (!mrst_sync_reg[1] && rst_cnt_reg == RST_CYC) |=> mod_rst_reg)
        else $error("reset pulse not recognised");
    rst_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $past(mod_rst_reg) |-> (flags_reg == '0) && data_not_ready_out)
        else $error("flags not held during module reset");
    los_flag_a: assert property (@(posedge clock_in) disable iff (rst_in)
        los_edge_s |-> los_seen_s)
        else $error("receive loss not flagged");
    ready_int_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(data_not_ready_out) |-> flags_reg[FLG_READY] ##1 !interrupt_out_n_out)
        else $error("ready did not raise interrupt");
    int_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (|flags_reg) |=> !interrupt_out_n_out)
        else $error("interrupt released with flag set");
    int_release_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (clr_go && set_vec == '0 && (flags_reg & ~clr_mask_reg) == '0) |=> ##1 interrupt_out_n_out)
        else $error("interrupt not released after clear");
    low_power_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(lp_sync_reg[1]) |=> low_power_active_out [*2])
        else $error("low power not entered");
    bus_ignore_a: assert property (@(posedge serial_clk_in) disable iff (rst_in)
        !en_sync_reg[1] |=> state_reg == ST_IDLE && sda_oe_n_out)
        else $error("bus answered during reset");
    addr_miss_a: assert property (@(posedge serial_clk_in) disable iff (rst_in)
        (ctl_ok && byte_done && state_reg == ST_ADDR && shift_reg[7:1] != DEV_ADDR)
        |=> state_reg == ST_IDLE && sda_oe_n_out)
        else $error("foreign address acknowledged");
    clr_stop_a: assert property (@(posedge serial_clk_in) disable iff (rst_in)
        (stop_det && |clr_pend_reg) |=> clr_tgl_reg != $past(clr_tgl_reg))
        else $error("clear not issued at stop");

endmodule

// file: mms_pkg.sv
//  Purpose: constants and types of the module management block
//  Assumes: 200 MHz core clock; serial sampling clock is separate
//  Notes:   times keep their printed unit, counts derive from them
package mms_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned T_INIT_MS = 2000;       // power-on / reset to ready
    localparam int unsigned INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned T_RST_PULSE_US = 2;     // least reset pulse
    localparam logic [8:0] RST_CYC = 9'(T_RST_PULSE_US * CLK_MHZ);
    localparam int unsigned T_LP_US = 100;          // low-power entry bound
    localparam int unsigned T_INT_ON_MS = 200;      // interrupt assert bound
    localparam int unsigned T_INTERRUPT_RELEASE_TIME_US = 500;
    localparam int unsigned T_LOS_MS = 100;         // receive-loss flag bound

    // ****************************************
    // serial bus and memory map
    // ****************************************
    localparam logic [6:0] DEV_ADDR = 7'h50;        // 8-bit form A0h/A1h
    localparam int unsigned PAGES = 4;
    localparam logic [7:0] ID_VALUE = 8'h5A;        // arbitrary value
    localparam logic [6:0] ID_OFS = 7'h00;
    localparam logic [6:0] STATUS_OFS = 7'h02;
    localparam logic [6:0] LOS_OFS = 7'h03;
    localparam logic [6:0] FAULT_OFS = 7'h04;
    localparam logic [6:0] MON_HI_OFS = 7'h16;
    localparam logic [6:0] MON_LO_OFS = 7'h17;
    localparam logic [6:0] PAGE_SEL_OFS = 7'h7F;
    localparam logic [7:0] PAGE_RST = 8'h00;

    // ****************************************
    // flag vector layout
    // ****************************************
    localparam int unsigned LANES = 4;
    localparam int unsigned FLAG_W = 9;
    localparam int unsigned FLG_READY = 0;          // status byte bit 1
    localparam int unsigned FLG_LOS_LSB = 1;
    localparam int unsigned FLG_FAULT_LSB = 5;
    localparam int unsigned DNR_BIT = 0;            // status byte bit 0

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WRITE,
        ST_ACK,
        ST_READ,
        ST_MACK
    } mms_state_e;

endpackage

// file: mms_host_model.sv
// Purpose: two-wire host model for the management block
// Assumes: open-drain bus, pull-up resolved in the bench
// Notes:   half bit 330 ns, above four 80 ns link clocks
`timescale 1ns/10ps
module mms_host_model
    import mms_pkg::*;
(
    output logic      scl_out,
    output logic      sda_low_out,
    input  wire logic sda_in
);
    localparam int HB = 330;
    localparam int QB = 120;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // sda moves well after scl falls: a move near the edge could pass for start or stop
    task automatic bit_io(input logic b, output logic r);
        #QB sda_low_out = !b;
        #(HB-QB) scl_out = 1'b1;
        #HB r = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic n_in, output logic [7:0] q, output logic n_out);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(n_in, n_out);
    endtask
    task automatic start_c();
        sda_low_out = 1'b1;
        #HB scl_out = 1'b0;
    endtask
    task automatic stop_c();
        #QB sda_low_out = 1'b1;
        #(HB-QB) scl_out = 1'b1;
        #HB sda_low_out = 1'b0;
        #HB;
    endtask
    // pointer write, then one data byte or a read pass; ok drops on a missing ack
    task automatic access(input logic [6:0] dev, input logic [7:0] ptr, input logic wr, input logic [7:0] wd,
                          input int n, output logic [15:0] rd, output logic ok);
        logic [7:0] q;
        logic       a;
        logic       b;
        rd = 16'h0000;
        start_c();
        byte_io({dev, 1'b0}, 1'b1, q, a);
        byte_io(ptr, 1'b1, q, b);
        ok = !a && !b;
        if (wr) byte_io(wd, 1'b1, q, b);
        ok = ok && !b;
        stop_c();
        if (!wr && ok) begin
            start_c();
            byte_io({dev, 1'b1}, 1'b1, q, a);
            ok = !a;
            for (int k = 0; k < n && ok; k++) begin
                byte_io(8'hFF, 1'(k == n - 1), q, b);
                rd = {rd[7:0], q};
            end
            stop_c();
        end
    endtask
endmodule

// file: module_mgmt_status_control_tb.sv
// Purpose: self-checking bench of the management block
// Assumes: short init count, host model on the two-wire bus
// Notes:   each test task drives and judges before it returns
`timescale 1ns/10ps
module module_mgmt_status_control_tb;
    import mms_pkg::*;
    localparam int unsigned INIT_N = 200;
    logic             clock_in, rst_in, serial_clk_in, module_reset_n_in, low_power_select_in;
    logic [LANES-1:0] rx_los_in, tx_fault_in;
    logic [15:0]      monitor_in, v;
    logic             scl, host_low, sda_out, sda_oe_n, int_n, lp_act, dnr, ok;
    wire              sda_wire;
    int               mismatches, checks_done, cycles;
    // pull-up: low only while a party pulls
    assign sda_wire = !(host_low || (!sda_oe_n && !sda_out));
    mms_top #(.INIT_CYCLES(INIT_N)) i_dut (.clock_in(clock_in), .rst_in(rst_in), .serial_clk_in(serial_clk_in),
        .module_reset_n_in(module_reset_n_in), .low_power_select_in(low_power_select_in), .rx_los_in(rx_los_in),
        .tx_fault_in(tx_fault_in), .monitor_in(monitor_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_n_out(sda_oe_n), .interrupt_out_n_out(int_n), .low_power_active_out(lp_act),
        .data_not_ready_out(dnr));
    mms_host_model i_host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda_wire));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string m);
        check_val({15'h0000, got}, {15'h0000, exp}, m);
    endtask
    // bounded wait, so a stuck output fails instead of hanging
    task automatic wait_lvl(ref logic s, input logic lvl, input int lim, input string m);
        for (int i = 0; i < lim && s !== lvl; i++) begin
            @(posedge clock_in);
            #1;
        end
        check_bit(s, lvl, m);
    endtask
    task automatic rd(input logic [7:0] p, input int n, input logic [15:0] e, input string m);
        i_host.access(DEV_ADDR, p, 1'b0, 8'h00, n, v, ok);
        check_bit(ok, 1'b1, m);
        check_val(v, e, m);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i_host.access(DEV_ADDR, p, 1'b1, d, 0, v, ok);
        check_bit(ok, 1'b1, "write ack");
    endtask
    task automatic t_init();
        check_bit(dnr, 1'b1, "not ready");
        wait_lvl(dnr, 1'b0, INIT_N + 8, "ready");
        wait_lvl(int_n, 1'b0, 4, "ready int");
        rd({1'b0, STATUS_OFS}, 1, 16'h0002, "status");
        wait_lvl(int_n, 1'b1, 16, "int release");
        rd({1'b0, ID_OFS}, 1, {8'h00, ID_VALUE}, "id");
        $display("init test done");
    endtask
    task automatic t_flags();
        @(posedge clock_in);
        rx_los_in <= 4'h5;
        tx_fault_in <= 4'h2;
        wait_lvl(int_n, 1'b0, 16, "event int");
        rd({1'b0, LOS_OFS}, 1, 16'h0005, "loss");
        check_bit(int_n, 1'b0, "int held");
        rd({1'b0, FAULT_OFS}, 1, 16'h0002, "fault");
        wait_lvl(int_n, 1'b1, 16, "int off");
        rd({1'b0, LOS_OFS}, 1, 16'h0000, "loss cleared");
        $display("flag test done");
    endtask
    task automatic t_pages();
        wr(8'h7F, 8'h01);
        wr(8'h80, 8'hC3);
        wr(8'h7F, 8'h02);
        wr(8'h80, 8'h3C);
        wr(8'h7F, 8'h01);
        rd(8'h7F, 2, 16'h01C3, "page one");
        rd({1'b0, MON_HI_OFS}, 2, 16'hBEEF, "monitor");
        i_host.access(7'h51, 8'h00, 1'b0, 8'h00, 1, v, ok);
        check_bit(ok, 1'b0, "foreign address");
        $display("page test done");
    endtask
    task automatic t_lp();
        @(posedge clock_in);
        low_power_select_in <= 1'b1;
        wait_lvl(lp_act, 1'b1, 8, "low power");
        @(posedge clock_in);
        low_power_select_in <= 1'b0;
        wait_lvl(lp_act, 1'b0, 8, "full power");
        $display("power test done");
    endtask
    task automatic t_mreset();
        @(posedge clock_in);
        module_reset_n_in <= 1'b0;
        repeat (100) @(posedge clock_in);
        module_reset_n_in <= 1'b1;
        repeat (20) @(posedge clock_in);
        check_bit(dnr, 1'b0, "short pulse");
        module_reset_n_in <= 1'b0;
        repeat (int'(RST_CYC) + 20) @(posedge clock_in);
        check_bit(dnr, 1'b1, "reset dnr");
        check_bit(int_n, 1'b1, "reset int");
        i_host.access(DEV_ADDR, 8'h00, 1'b0, 8'h00, 1, v, ok);
        check_bit(ok, 1'b0, "bus in reset");
        @(posedge clock_in);
        module_reset_n_in <= 1'b1;
        wait_lvl(dnr, 1'b0, INIT_N + 12, "re-init");
        wait_lvl(int_n, 1'b0, 4, "re-init int");
        $display("reset test done");
    endtask
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = !clock_in;
    end
    // link clock offset so its edges never coincide with core clock edges
    initial begin
        serial_clk_in = 1'b0;
        #13.3;
        forever #40 serial_clk_in = !serial_clk_in;
    end
    // ceiling well above the expected run of about 65k cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        rst_in = 1'b1;
        module_reset_n_in = 1'b1;
        low_power_select_in = 1'b0;
        rx_los_in = 4'h0;
        tx_fault_in = 4'h0;
        monitor_in = 16'hBEEF;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        t_init();
        t_flags();
        t_pages();
        t_lp();
        t_mreset();
        close_out();
    end
endmodule
